// [verilog/fbsw_pkg.sv]
// fbsw_pkg: register map, field layout, reset values and timing for the
// fieldbus slave state and watchdog block.
// assumes a 50 MHz hclk and an AHB-Lite register bus with 32-bit data.
package fbsw_pkg;

  // register byte offsets
  localparam logic [7:0] FBSW_CTRL_OFS    = 8'h00;
  localparam logic [7:0] FBSW_MULT_OFS    = 8'h04;
  localparam logic [7:0] FBSW_SMWD_OFS    = 8'h08;
  localparam logic [7:0] FBSW_PDIWD_OFS   = 8'h0c;
  localparam logic [7:0] FBSW_STATUS_OFS  = 8'h10;
  localparam logic [7:0] FBSW_REQ_OFS     = 8'h14;

  // control fields
  localparam int FBSW_CTRL_SMEN_BIT  = 0;
  localparam int FBSW_CTRL_PDIEN_BIT = 1;

  // status fields
  localparam int FBSW_ST_STATE_LSB = 0;
  localparam int FBSW_ST_SMTRIP    = 4;
  localparam int FBSW_ST_PDITRIP   = 5;
  localparam int FBSW_ST_REJECT    = 6;
  localparam int FBSW_ST_MBXOK     = 8;
  localparam int FBSW_ST_PDOK      = 9;
  localparam int FBSW_ST_FILEOK    = 10;
  localparam int FBSW_ST_OUTEN     = 11;

  // reset values
  localparam logic [1:0]  FBSW_CTRL_RST  = 2'h3;
  localparam logic [15:0] FBSW_MULT_RST  = 16'h09c2;
  localparam logic [15:0] FBSW_SMWD_RST  = 16'h03e8;
  localparam logic [15:0] FBSW_PDIWD_RST = 16'h03e8;
  localparam logic [15:0] FBSW_MULT_MIN  = 16'h0001;

  // terminal clock: one basic tick is 40 ns
  localparam int FBSW_CLK_HZ     = 50_000_000;
  localparam int FBSW_TERM_NS    = 40;
  localparam int FBSW_CLK_NS     = 1_000_000_000 / FBSW_CLK_HZ;
  localparam int FBSW_BASE_CYC_I = (FBSW_TERM_NS + FBSW_CLK_NS - 1) / FBSW_CLK_NS;
  localparam logic [1:0] FBSW_BASE_CYC = FBSW_BASE_CYC_I[1:0];
  localparam logic [16:0] FBSW_MULT_EXTRA = 17'h00002;

  // slave states, codes as reported in the status register
  typedef enum logic [3:0] {
    FBSW_INIT   = 4'h1,
    FBSW_PREOP  = 4'h2,
    FBSW_BOOT   = 4'h3,
    FBSW_SAFEOP = 4'h4,
    FBSW_OP     = 4'h8
  } fbsw_state_t;

endpackage

// [verilog/fbsw_wdog.sv]
// fbsw_wdog: one watchdog counter driven by the shared tick.
// assumes tick is a one-cycle pulse from the shared divider in the top.
`timescale 1ns/1ps
module fbsw_wdog
  import fbsw_pkg::*;
(
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // control
  input  wire logic        enable,
  input  wire logic [15:0] timer_value,
  input  wire logic        tick,
  input  wire logic        restart,
  // status
  output logic             tripped
);
  logic [15:0] count;
  wire         armed      = enable && (timer_value != 16'h0000);
  wire         next_trip  = armed && tick && (count + 16'h0001 >= timer_value);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      count <= 16'h0000;
    else if (restart || !armed)
      count <= 16'h0000;
    else if (tick && !tripped)
      count <= count + 16'h0001;
  end

  // restart wins over an expiry in the same cycle
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      tripped <= 1'b0;
    else if (restart || !armed)
      tripped <= 1'b0;
    else if (next_trip)
      tripped <= 1'b1;
  end

  trip_cause_a: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(tripped) |-> $past(armed) && $past(tick))
    else $error("watchdog tripped without an armed tick");
  zero_off_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (timer_value == 16'h0000) |=> !tripped)
    else $error("watchdog tripped with zero timer value");
  restart_clear_a: assert property (@(posedge hclk) disable iff (!hresetn)
    restart |=> !tripped && (count == 16'h0000))
    else $error("restart did not clear the watchdog");
endmodule // fbsw_wdog

// [verilog/fbsw_top.sv]
// fbsw_top: slave state machine, sync-manager and interface watchdogs,
// AHB-Lite register slave.
// assumes a single AHB-Lite master; pd_done, pdi_access and state requests
// come from the bus side of the slave controller on the same clock.
//
// How it works
// - restart SM watchdog on completed exchange only
// - SM expiry forces outputs off, state kept
// - both watchdogs default to 100 ms
// - PDI watchdog trips on no local access
// - shared multiplier, separate timer values
// - tick equals multiplier plus two basic ticks
// - timer 0..65535, multiplier 1..65535
// - SM timer defaults to 1000 ticks
// - zero SM timer disables the watchdog
// - reset enters Init, no exchange allowed
// - Init to Pre-Op needs valid mailbox
// - Pre-Op allows mailbox, rejects process data
// - Safe-Op entry from Pre-Op checks channels, copies inputs
// - Safe-Op exchanges data, outputs held safe
// - Op applies master output data
// - Boot reachable only from Init
// - Boot allows only file-access mailbox
`timescale 1ns/1ps
module fbsw_top
  import fbsw_pkg::*;
(
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [7:0]  haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // link-side events
  input  wire logic        pd_done,
  input  wire logic        mbx_cfg_ok,
  input  wire logic        pd_cfg_ok,
  input  wire logic        dc_cfg_ok,
  // application side
  input  wire logic        pdi_access,
  input  wire logic [7:0]  out_data,
  // process outputs and status
  output logic [7:0]       process_out,
  output logic             input_copy,
  output logic [3:0]       slave_state,
  output logic             sm_tripped,
  output logic             pdi_tripped
);
  fbsw_state_t state;
  fbsw_state_t next_state;
  logic [1:0]  ctrl;
  logic [15:0] mult;
  logic [15:0] smwd;
  logic [15:0] pdiwd;
  logic        reject;
  logic [1:0]  base_cnt;
  logic [16:0] tick_cnt;
  logic        tick;
  logic        req_valid;
  logic [3:0]  req_state;
  logic        a_wr;
  logic        a_rd;
  logic [7:0]  a_addr;
  logic        sm_trip;
  logic        pdi_trip;

  // bus address phase
  wire        take     = hsel && hready && htrans[1];
  wire [15:0] wdata16  = hwdata[15:0];
  wire        wr_ctrl  = a_wr && (a_addr == FBSW_CTRL_OFS);
  wire        wr_mult  = a_wr && (a_addr == FBSW_MULT_OFS);
  wire        wr_smwd  = a_wr && (a_addr == FBSW_SMWD_OFS);
  wire        wr_pdiwd = a_wr && (a_addr == FBSW_PDIWD_OFS);
  wire        wr_req   = a_wr && (a_addr == FBSW_REQ_OFS);
  wire        rd_stat  = a_rd && (a_addr == FBSW_STATUS_OFS);

  // access gating per state
  wire mbx_ok  = (state == FBSW_PREOP) || (state == FBSW_SAFEOP)
               || (state == FBSW_OP);
  wire pd_ok   = (state == FBSW_SAFEOP) || (state == FBSW_OP);
  wire file_ok = (state == FBSW_BOOT);
  wire pd_good = pd_done && pd_ok;

  // transition check
  wire [3:0] rq = req_state;
  wire to_init  = (rq == FBSW_INIT);
  wire to_pre   = (rq == FBSW_PREOP) && (state == FBSW_INIT ||
                  state == FBSW_SAFEOP || state == FBSW_OP) &&
                  (state != FBSW_INIT || mbx_cfg_ok);
  wire to_safe  = (rq == FBSW_SAFEOP) && ((state == FBSW_PREOP &&
                  pd_cfg_ok && dc_cfg_ok) || state == FBSW_OP);
  wire to_op    = (rq == FBSW_OP) && (state == FBSW_SAFEOP);
  wire to_boot  = (rq == FBSW_BOOT) && (state == FBSW_INIT);
  wire to_same  = (rq == state);
  wire legal    = to_init || to_pre || to_safe || to_op || to_boot || to_same;

  always_comb
  begin
    next_state = state;
    if (req_valid && legal && !to_same)
      next_state = fbsw_state_t'(rq);
  end

  // bit 7 and bits 31:11 read as zero
  wire [31:0] status = {20'h00000, 1'b0, file_ok, pd_ok, mbx_ok, 1'b0,
                        reject, pdi_trip, sm_trip, state};
  wire [31:0] rmux   = (haddr == FBSW_CTRL_OFS)  ? {30'h0, ctrl}  :
                       (haddr == FBSW_MULT_OFS)  ? {16'h0, mult}  :
                       (haddr == FBSW_SMWD_OFS)  ? {16'h0, smwd}  :
                       (haddr == FBSW_PDIWD_OFS) ? {16'h0, pdiwd} :
                       (haddr == FBSW_STATUS_OFS) ? status : 32'h00000000;

  // tick divider: (mult + 2) basic 40 ns ticks per watchdog tick
  wire        base_tick = (base_cnt == FBSW_BASE_CYC - 2'h1);
  wire [16:0] tick_top  = {1'b0, mult} + FBSW_MULT_EXTRA - 17'h00001;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      base_cnt <= 2'h0;
    else
      base_cnt <= base_tick ? 2'h0 : base_cnt + 2'h1;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      tick_cnt <= 17'h00000;
      tick     <= 1'b0;
    end
    else
    begin
      tick <= base_tick && (tick_cnt >= tick_top);
      if (base_tick)
        tick_cnt <= (tick_cnt >= tick_top) ? 17'h00000 : tick_cnt + 17'h00001;
    end
  end

  // bus data phase and registers
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      a_wr   <= 1'b0;
      a_rd   <= 1'b0;
      a_addr <= 8'h00;
    end
    else
    begin
      a_wr   <= take && hwrite;
      a_rd   <= take && !hwrite;
      a_addr <= haddr;
    end
  end

  // zero multiplier is clamped, so a tick never vanishes
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ctrl  <= FBSW_CTRL_RST;
      mult  <= FBSW_MULT_RST;
      smwd  <= FBSW_SMWD_RST;
      pdiwd <= FBSW_PDIWD_RST;
    end
    else
    begin
      if (wr_ctrl)
        ctrl <= hwdata[1:0];
      if (wr_mult)
        mult <= (wdata16 < FBSW_MULT_MIN) ? FBSW_MULT_MIN : wdata16;
      if (wr_smwd)
        smwd <= wdata16;
      if (wr_pdiwd)
        pdiwd <= wdata16;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      req_valid <= 1'b0;
      req_state <= 4'h0;
    end
    else
    begin
      req_valid <= wr_req;
      req_state <= hwdata[3:0];
    end
  end

  // state register; sticky reject cleared by a status read, set wins
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state  <= FBSW_INIT;
      reject <= 1'b0;
    end
    else
    begin
      state <= next_state;
      if (req_valid && !legal)
        reject <= 1'b1;
      else if (rd_stat)
        reject <= 1'b0;
    end
  end

  fbsw_wdog u_smwd (
    .hclk        (hclk),
    .hresetn     (hresetn),
    .enable      (ctrl[FBSW_CTRL_SMEN_BIT]),
    .timer_value (smwd),
    .tick        (tick),
    .restart     (pd_good),
    .tripped     (sm_trip)
  );

  fbsw_wdog u_pdiwd (
    .hclk        (hclk),
    .hresetn     (hresetn),
    .enable      (ctrl[FBSW_CTRL_PDIEN_BIT]),
    .timer_value (pdiwd),
    .tick        (tick),
    .restart     (pdi_access),
    .tripped     (pdi_trip)
  );

  // outputs, all registered
  wire out_live = (next_state == FBSW_OP) && !sm_trip;
  wire copy_now = req_valid && to_safe && (state == FBSW_PREOP);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      process_out <= 8'h00;
      input_copy  <= 1'b0;
      slave_state <= FBSW_INIT;
      sm_tripped  <= 1'b0;
      pdi_tripped <= 1'b0;
      hrdata      <= 32'h00000000;
      hreadyout   <= 1'b1;
      hresp       <= 1'b0;
    end
    else
    begin
      process_out <= out_live ? out_data : 8'h00;
      input_copy  <= copy_now;
      slave_state <= next_state;
      sm_tripped  <= sm_trip;
      pdi_tripped <= pdi_trip;
      if (take && !hwrite)
        hrdata <= rmux;
    end
  end

  safe_out_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (state != FBSW_OP) |-> (process_out == 8'h00))
    else $error("outputs live outside Op");
  trip_clear_a: assert property (@(posedge hclk) disable iff (!hresetn)
    sm_trip |=> (process_out == 8'h00))
    else $error("outputs not cleared on sync-manager trip");
  trip_keep_a: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(sm_trip) && !$past(req_valid) |-> $stable(state))
    else $error("state changed by watchdog trip");
  boot_entry_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (state == FBSW_BOOT) && !$past(state == FBSW_BOOT) |-> $past(state) == FBSW_INIT)
    else $error("boot entered from a state other than Init");
  preop_check_a: assert property (@(posedge hclk) disable iff (!hresetn)
    $past(state) == FBSW_INIT && state == FBSW_PREOP |-> $past(mbx_cfg_ok))
    else $error("Pre-Op entered without mailbox check");
  op_entry_a: assert property (@(posedge hclk) disable iff (!hresetn)
    state == FBSW_OP && $past(state) != FBSW_OP |-> $past(state) == FBSW_SAFEOP)
    else $error("Op entered from an illegal state");
  reject_flag_a: assert property (@(posedge hclk) disable iff (!hresetn)
    req_valid && !legal |=> reject && $stable(state))
    else $error("illegal request not rejected");
  pd_gate_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (state == FBSW_PREOP || state == FBSW_INIT || state == FBSW_BOOT) |-> !pd_good)
    else $error("process data accepted outside Safe-Op and Op");
endmodule // fbsw_top

// [tb/fbsw_master_model.sv]
// fbsw_master_model: behavioural fieldbus master seen from the slave side.
// assumes the bench steers cyclic traffic and configuration levels.
`timescale 1ns/1ps
module fbsw_master_model
(
  // clock and reset
  input  wire logic       hclk,
  input  wire logic       hresetn,
  // bench control
  input  wire logic       run,
  input  wire logic [2:0] cfg,
  // slave-facing events and data
  output logic            pd_done,
  output logic            mbx_cfg_ok,
  output logic            pd_cfg_ok,
  output logic            dc_cfg_ok,
  output logic [7:0]      out_data
);
  logic [2:0] cnt;

  // one completed exchange every 5 cycles, well inside the shortest timeout
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cnt     <= 3'h0;
      pd_done <= 1'b0;
    end
    else
    begin
      cnt     <= (cnt == 3'h4) ? 3'h0 : cnt + 3'h1;
      pd_done <= run && (cnt == 3'h4);
    end
  end

  assign mbx_cfg_ok = cfg[0];
  assign pd_cfg_ok  = cfg[1];
  assign dc_cfg_ok  = cfg[2];
  // outputs valid long before any op request
  assign out_data   = 8'h5a;
endmodule // fbsw_master_model

// [tb/fbsw_tb_top.sv]
// fbsw_tb_top: self-checking bench for the slave state and watchdog block.
// assumes a single ahb-lite master here and the master model on the link side.
`timescale 1ns/1ps
module fbsw_tb_top;
  import fbsw_pkg::*;
  logic        hclk, hresetn, hsel, hwrite, run, pdi_run;
  logic        pdi_access = 1'b0;
  logic [7:0]  haddr, out_data, process_out;
  logic [1:0]  htrans;
  logic [2:0]  hsize, cfg;
  logic [31:0] hwdata, hrdata, d;
  logic        hreadyout, hresp, pd_done, mbx_cfg_ok, pd_cfg_ok, dc_cfg_ok;
  logic        input_copy, sm_tripped, pdi_tripped;
  logic [3:0]  slave_state;
  int          errors, cmp_count, copies;

  fbsw_top i_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .pd_done, .mbx_cfg_ok, .pd_cfg_ok,
    .dc_cfg_ok, .pdi_access, .out_data, .process_out, .input_copy, .slave_state,
    .sm_tripped, .pdi_tripped);
  fbsw_master_model i_master (.hclk, .hresetn, .run, .cfg, .pd_done, .mbx_cfg_ok,
    .pd_cfg_ok, .dc_cfg_ok, .out_data);

  initial
  begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end
  // application access every other cycle while enabled
  always @(posedge hclk) pdi_access <= pdi_run & ~pdi_access;
  always @(posedge hclk) if (input_copy === 1'b1) copies++;

  task wrap_up;
    if (errors == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task wt(input int k);
    repeat (k) @(posedge hclk);
  endtask

  // one single transfer; read data lands in d
  task bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= 2'h2;
    hwrite <= w;
    hsize  <= 3'h2;
    @(posedge hclk);
    while (hreadyout !== 1'b1)
      @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'b1)
      @(posedge hclk);
    d = hrdata;
  endtask

  task req(input logic [3:0] s);
    bus(1'b1, FBSW_REQ_OFS, {28'h0, s});
    wt(5);
  endtask

  task t_reset;
    bus(1'b0, FBSW_CTRL_OFS, 32'h0);   chk(d, 32'h3);
    bus(1'b0, FBSW_MULT_OFS, 32'h0);   chk(d, 32'h9c2);
    bus(1'b0, FBSW_SMWD_OFS, 32'h0);   chk(d, 32'h3e8);
    bus(1'b0, FBSW_PDIWD_OFS, 32'h0);  chk(d, 32'h3e8);
    bus(1'b0, 8'h20, 32'h0);           chk(d, 32'h0);
    chk({hreadyout, hresp}, 2'b10);
    bus(1'b0, FBSW_STATUS_OFS, 32'h0); chk(d[10:0], 11'h001);
  endtask

  task t_states;
    req(FBSW_OP);     chk(slave_state, FBSW_INIT);
    bus(1'b0, FBSW_STATUS_OFS, 32'h0); chk(d[6], 1'b1);
    req(FBSW_PREOP);  chk(slave_state, FBSW_INIT);
    cfg <= 3'b001;
    req(FBSW_PREOP);  chk(slave_state, FBSW_PREOP);
    bus(1'b0, FBSW_STATUS_OFS, 32'h0); chk(d[10:8], 3'b001);
    req(FBSW_BOOT);   chk(slave_state, FBSW_PREOP);
    cfg <= 3'b111;
    req(FBSW_SAFEOP); chk(slave_state, FBSW_SAFEOP);
    chk(copies, 1);
    chk(process_out, 8'h00);
    bus(1'b0, FBSW_STATUS_OFS, 32'h0); chk(d[10:8], 3'b011);
    req(FBSW_OP);     chk(slave_state, FBSW_OP);
    chk(process_out, 8'h5a);
  endtask

  task t_wdog;
    bus(1'b1, FBSW_MULT_OFS, 32'h0);
    bus(1'b0, FBSW_MULT_OFS, 32'h0); chk(d, 32'h1);
    bus(1'b1, FBSW_SMWD_OFS, 32'h3);
    bus(1'b1, FBSW_PDIWD_OFS, 32'h3);
    run <= 1'b1;
    wt(60);  chk(sm_tripped, 1'b0);
    run <= 1'b0;
    wt(40);  chk(sm_tripped, 1'b1);
    chk(process_out, 8'h00);
    chk(slave_state, FBSW_OP);
    chk(pdi_tripped, 1'b0);
    run <= 1'b1;
    wt(10);  chk(sm_tripped, 1'b0);
    bus(1'b1, FBSW_SMWD_OFS, 32'ha);
    run <= 1'b0;
    wt(45);  chk(sm_tripped, 1'b0);
    wt(35);  chk(sm_tripped, 1'b1);
    bus(1'b1, FBSW_SMWD_OFS, 32'h0);
    wt(60);  chk(sm_tripped, 1'b0);
    chk(process_out, 8'h5a);
    pdi_run <= 1'b0;
    wt(40);  chk(pdi_tripped, 1'b1);
  endtask

  task t_boot;
    req(FBSW_INIT);   chk(slave_state, FBSW_INIT);
    req(FBSW_BOOT);   chk(slave_state, FBSW_BOOT);
    bus(1'b0, FBSW_STATUS_OFS, 32'h0); chk(d[10:8], 3'b100);
    req(FBSW_PREOP);  chk(slave_state, FBSW_BOOT);
    chk(process_out, 8'h00);
  endtask

  initial
  begin
    {hresetn, hsel, hwrite, run} = 4'h0;
    pdi_run = 1'b1;
    haddr = 8'h00;
    htrans = 2'h0;
    hsize = 3'h2;
    cfg = 3'b000;
    hwdata = 32'h0;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset;
    t_states;
    t_wdog;
    t_boot;
    wrap_up;
  end

  // hang guard, generous against the few hundred cycles the tests take
  initial
  begin
    #(20 * 20000);
    errors++;
    wrap_up;
  end
endmodule // fbsw_tb_top
